// File: hw/reload_timer.sv
// Contract
// - one-shot reload raises interrupt, count becomes 0001H, enable clears, stops.
// - one-shot reload inverts output for exactly one clock when output enabled.
// - continuous reload raises interrupt, count becomes 0001H, keeps counting.
// - continuous mode start count applies first pass only, later from 0001H.
// - one-shot, continuous, pwm count prescaled clock, never the input pin.
// - continuous reload inverts output and holds until next reload.
// - counter mode counts selected input edge, no prescaler; polarity picks edge.
// - counter reload raises interrupt, count 0001H, inverts output if enabled.
// - counter edge select also sets the initial output level.
// - pwm toggles output at match; reload interrupts, count 0001H, continues.
// - polarity 1 pwm: start high, low on match, high at reload.
// - polarity 0 pwm: start low, high on match, low at reload.
// - pwm written start affects first period only, then 0001H.
// - prescaler divides system clock by 1 up to 128.
// - count at FFFFH without reload wraps to 0000H and continues.
`timescale 1ns/1ps
`include "timer_params.svh"

module reload_timer (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        timer_in,
  output logic             timer_out,
  output logic             timer_out_oe,
  output logic             timer_irq
);

  timer_pkg::ctrl_t ctrl_r;
  logic [15:0]      count_r;
  logic [15:0]      reload_r;
  logic [15:0]      match_r;
  logic [6:0]       presc_cnt_r;
  logic             in_s1_r;
  logic             in_s2_r;
  logic             in_s3_r;
  logic             level_r;
  logic             level_nxt;
  logic             out_r;
  logic             irq_r;
  logic             aw_hold_r;
  logic             w_hold_r;
  logic [7:0]       awaddr_r;
  logic [31:0]      wdata_r;
  logic [3:0]       wstrb_r;
  logic             bvalid_r;
  logic [1:0]       bresp_r;
  logic             rvalid_r;
  logic [1:0]       rresp_r;
  logic [31:0]      rdata_r;
  logic             wr_go;
  logic             wr_ctrl;
  logic             wr_count;
  logic             wr_reload;
  logic             wr_match;
  logic [31:0]      ctrl_wr;
  logic [31:0]      count_wr;
  logic [6:0]       div_m1;
  logic             sys_tick;
  logic             edge_hit;
  logic             tick;
  logic             reload_hit;
  logic             match_hit;
  logic             is_oneshot;
  logic             is_counter;
  logic             is_pwm;

  // byte-lane merge of a write into an old value
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // address decode: true when offset names a register
  function automatic logic addr_known(input logic [7:0] a);
    return (a == `TMR_CTRL_OFS) || (a == `TMR_COUNT_OFS) ||
           (a == `TMR_RELOAD_OFS) || (a == `TMR_MATCH_OFS) ||
           (a == `TMR_STATUS_OFS);
  endfunction

  // ---------------- bus slave ----------------

  assign s_axi_awready = ~aw_hold_r & ~bvalid_r;
  assign s_axi_wready  = ~w_hold_r & ~bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;

  // write strobes once address and data are both held
  assign wr_go     = aw_hold_r & w_hold_r & ~bvalid_r;
  assign wr_ctrl   = wr_go & (awaddr_r == `TMR_CTRL_OFS);
  assign wr_count  = wr_go & (awaddr_r == `TMR_COUNT_OFS);
  assign wr_reload = wr_go & (awaddr_r == `TMR_RELOAD_OFS);
  assign wr_match  = wr_go & (awaddr_r == `TMR_MATCH_OFS);
  assign ctrl_wr   = lane_merge({24'h000000, ctrl_r}, wdata_r, wstrb_r);
  assign count_wr  = lane_merge({16'h0000, count_r}, wdata_r, wstrb_r);

  // write address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h00000000;
      wstrb_r   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_hold_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end else if (wr_go) begin
        w_hold_r <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `AXI_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= addr_known(awaddr_r) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // read channel, one cycle after address taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r  <= `AXI_RESP_OKAY;
      rdata_r  <= 32'h00000000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rresp_r  <= addr_known(s_axi_araddr) ? `AXI_RESP_OKAY
                                           : `AXI_RESP_SLVERR;
      case (s_axi_araddr)
        `TMR_CTRL_OFS:   rdata_r <= {24'h000000, ctrl_r};
        `TMR_COUNT_OFS:  rdata_r <= {16'h0000, count_r};
        `TMR_RELOAD_OFS: rdata_r <= {16'h0000, reload_r};
        `TMR_MATCH_OFS:  rdata_r <= {16'h0000, match_r};
        `TMR_STATUS_OFS: rdata_r <= {30'h00000000, ctrl_r.en, out_r};
        default:         rdata_r <= 32'h00000000;
      endcase
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ---------------- timer core ----------------

  assign is_oneshot = ctrl_r.mode == timer_pkg::MODE_ONESHOT;
  assign is_counter = ctrl_r.mode == timer_pkg::MODE_COUNTER;
  assign is_pwm     = ctrl_r.mode == timer_pkg::MODE_PWM;

  // prescale divide of 2^presc, 1 to 128
  assign div_m1   = 7'((8'h01 << ctrl_r.presc) - 8'h01);
  assign sys_tick = ctrl_r.en & (presc_cnt_r == div_m1);
  // edge chosen by polarity, from synchronised samples
  assign edge_hit = ctrl_r.output_polarity_select ? (in_s2_r & ~in_s3_r)
                                                  : (~in_s2_r & in_s3_r);
  // counter mode bypasses prescaler; others never see the pin
  assign tick = is_counter ? (ctrl_r.en & edge_hit) : sys_tick;
  assign reload_hit = tick & (count_r == reload_r);
  assign match_hit  = tick & is_pwm & (count_r == match_r) & ~reload_hit;

  // input pin synchroniser plus edge history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_s1_r <= 1'b0;
      in_s2_r <= 1'b0;
      in_s3_r <= 1'b0;
    end else begin
      in_s1_r <= timer_in;
      in_s2_r <= in_s1_r;
      in_s3_r <= in_s2_r;
    end
  end

  // prescaler, held clear while disabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_cnt_r <= 7'h00;
    end else if (!ctrl_r.en || sys_tick) begin
      presc_cnt_r <= 7'h00;
    end else begin
      presc_cnt_r <= presc_cnt_r + 7'h01;
    end
  end

  // control register; one-shot expiry drops enable unless written
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= timer_pkg::ctrl_t'(`TMR_CTRL_RST);
    end else if (wr_ctrl) begin
      ctrl_r <= timer_pkg::ctrl_t'(ctrl_wr[`TMR_CTRL_WIDTH-1:0]);
    end else if (reload_hit && is_oneshot) begin
      ctrl_r.en <= 1'b0;
    end
  end

  // reload and match values
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_r <= `TMR_RELOAD_RST;
      match_r  <= `TMR_MATCH_RST;
    end else begin
      if (wr_reload) begin
        reload_r <= lane_merge({16'h0000, reload_r}, wdata_r, wstrb_r)
                    [15:0];
      end
      if (wr_match) begin
        match_r <= lane_merge({16'h0000, match_r}, wdata_r, wstrb_r)
                   [15:0];
      end
    end
  end

  // count: start value from software, 0001H after each reload
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= `TMR_COUNT_RST;
    end else if (wr_count) begin
      count_r <= count_wr[15:0];
    end else if (reload_hit) begin
      count_r <= `TMR_RESTART;
    end else if (tick) begin
      count_r <= count_r + 16'h0001;
    end
  end

  // output level per mode; polarity gives the idle level
  always_comb begin
    level_nxt = level_r;
    if (!ctrl_r.en) begin
      level_nxt = ctrl_r.output_polarity_select;
    end else begin
      case (ctrl_r.mode)
        timer_pkg::MODE_ONESHOT: begin
          // hold start level; a polarity flip lands only at expiry
          level_nxt = level_r;
        end
        timer_pkg::MODE_CONTINUOUS,
        timer_pkg::MODE_COUNTER: begin
          if (reload_hit) begin
            level_nxt = ~level_r;
          end
        end
        timer_pkg::MODE_PWM: begin
          if (reload_hit) begin
            level_nxt = ctrl_r.output_polarity_select;
          end else if (match_hit) begin
            level_nxt = ~ctrl_r.output_polarity_select;
          end
        end
        default: begin
          level_nxt = level_r;
        end
      endcase
    end
  end

  // output flops and interrupt pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_r <= 1'b0;
      out_r   <= 1'b0;
      irq_r   <= 1'b0;
    end else begin
      level_r <= level_nxt;
      out_r   <= level_nxt ^ (reload_hit & is_oneshot);
      irq_r   <= reload_hit;
    end
  end

  assign timer_out    = out_r;
  assign timer_out_oe = ctrl_r.out_af;
  assign timer_irq    = irq_r;

endmodule // reload_timer

// File: hw/timer_params.svh
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

// register byte offsets
`define TMR_CTRL_OFS      8'h00
`define TMR_COUNT_OFS     8'h04
`define TMR_RELOAD_OFS    8'h08
`define TMR_MATCH_OFS     8'h0C
`define TMR_STATUS_OFS    8'h10

// control field positions
`define TMR_CTRL_EN_BIT   0
`define TMR_CTRL_MODE_LSB 1
`define TMR_CTRL_PRE_LSB  3
`define TMR_CTRL_POL_BIT  6
`define TMR_CTRL_AF_BIT   7
`define TMR_CTRL_WIDTH    8

// reset values
`define TMR_CTRL_RST      8'h00
`define TMR_COUNT_RST     16'h0000
`define TMR_RELOAD_RST    16'h0000
`define TMR_MATCH_RST     16'h0000

// count restored at every reload
`define TMR_RESTART       16'h0001

// bus responses
`define AXI_RESP_OKAY     2'h0
`define AXI_RESP_SLVERR   2'h2

// system clock
`define TMR_CLK_PERIOD_NS 100

`endif

// File: hw/timer_pkg.sv
package timer_pkg;

  // operating modes
  typedef enum logic [1:0] {
    MODE_ONESHOT,
    MODE_CONTINUOUS,
    MODE_COUNTER,
    MODE_PWM
  } mode_t;

  // control register layout, msb first
  typedef struct packed {
    logic       out_af;
    logic       output_polarity_select;
    logic [2:0] presc;
    mode_t      mode;
    logic       en;
  } ctrl_t;

  // status register layout
  typedef struct packed {
    logic en;
    logic out_level;
  } status_t;

endpackage

// File: verification/reload_timer_props.sv
`timescale 1ns/1ps
`include "timer_params.svh"
module reload_timer_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        timer_out,
  input wire logic        timer_out_oe,
  input wire logic        timer_irq
);
  timer_pkg::ctrl_t ctrl_r;
  timer_pkg::ctrl_t pend_r;
  logic             pend_v_r;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // shadow of the control register, lands when the write completes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r   <= '0;
      pend_r   <= '0;
      pend_v_r <= 1'b0;
    end else begin
      pend_v_r <= s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
                  s_axi_wready && s_axi_awaddr == `TMR_CTRL_OFS;
      pend_r   <= timer_pkg::ctrl_t'(s_axi_wdata[7:0]);
      if (pend_v_r) ctrl_r <= pend_r;
    end
  end
  a_irq_single: assert property (
    timer_irq |=> !timer_irq) else $error("irq wider than one cycle");
  a_oe_follows: assert property (
    $stable(ctrl_r.out_af) [*2] |-> timer_out_oe == ctrl_r.out_af)
    else $error("output enable differs from control");
  a_shot_blip: assert property (
    ctrl_r.mode == timer_pkg::MODE_ONESHOT && ctrl_r.out_af && timer_irq
    && $stable(ctrl_r) |-> timer_out != $past(timer_out) ##1
    timer_out == ctrl_r.output_polarity_select)
    else $error("one-shot output blip wrong");
  a_shot_stop: assert property (
    ctrl_r.mode == timer_pkg::MODE_ONESHOT && timer_irq |=> !timer_irq [*8])
    else $error("one-shot kept running");
  a_reload_toggle: assert property (
    (ctrl_r.mode == timer_pkg::MODE_CONTINUOUS ||
     ctrl_r.mode == timer_pkg::MODE_COUNTER) && ctrl_r.out_af && timer_irq
    |-> timer_out != $past(timer_out)) else $error("no toggle at reload");
  a_cont_hold: assert property (
    ($stable(ctrl_r) && ctrl_r.en) [*2] ##0
    (ctrl_r.mode == timer_pkg::MODE_CONTINUOUS && !timer_irq)
    |-> $stable(timer_out)) else $error("output moved between reloads");
  a_pwm_reload: assert property (
    ctrl_r.mode == timer_pkg::MODE_PWM && ctrl_r.out_af && timer_irq
    |-> timer_out == ctrl_r.output_polarity_select)
    else $error("pwm level wrong at reload");
  a_idle_level: assert property (
    ($stable(ctrl_r) && !ctrl_r.en &&
     ctrl_r.mode != timer_pkg::MODE_ONESHOT) [*2]
    |-> timer_out == ctrl_r.output_polarity_select)
    else $error("idle output differs from polarity");
  c_cont: cover property (ctrl_r.mode == timer_pkg::MODE_CONTINUOUS && timer_irq);
  c_pwm: cover property (ctrl_r.mode == timer_pkg::MODE_PWM && timer_irq);
  c_count: cover property (ctrl_r.mode == timer_pkg::MODE_COUNTER && timer_irq);
endmodule // reload_timer_props

// File: verification/pin_source.sv
`timescale 1ns/1ps
module pin_source (
  input  wire logic       aclk,
  input  wire logic       run,
  input  wire logic [3:0] half,
  output logic            pin,
  output int              rises,
  output int              falls
);
  int cnt;
  // idle values
  initial begin
    pin = 1'b0;
    cnt = 0;
    rises = 0;
    falls = 0;
  end
  // toggle every half cycles, half at least 2 keeps a quarter rate
  always @(posedge aclk) begin
    if (run && cnt >= half - 1) begin
      pin <= ~pin;
      cnt <= 0;
      if (!pin) rises <= rises + 1;
      else falls <= falls + 1;
    end else if (run) cnt <= cnt + 1;
  end
endmodule // pin_source

// File: verification/reload_timer_bench.sv
`timescale 1ns/1ps
`include "timer_params.svh"
module reload_timer_bench;
  logic        aclk = 1'b0, aresetn = 1'b0, run = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF, half = 4'h2;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, timer_in, timer_out, timer_out_oe, timer_irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          mismatches = 0, compares = 0, cyc = 0, t0, rises, falls;
  int          irq_q[$];
  reload_timer dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .timer_in, .timer_out, .timer_out_oe,
    .timer_irq);
  pin_source src (.aclk, .run, .half, .pin(timer_in), .rises, .falls);
  // clock
  always #50 aclk = ~aclk;
  // cycle count and interrupt time stamps
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (timer_irq === 1'b1) irq_q.push_back(cyc);
  end
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %0h expected %0h", $time, m, got, exp);
    end
  endtask
  task automatic tout(input string m);
    mismatches++;
    $display("mismatch at %0t: %s timed out", $time, m);
    stop_test();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    bit aw = 0, w = 0, b = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 50 && !b; i++) begin
      @(posedge aclk);
      if (s_axi_bvalid === 1'b1 && aw && w) b = 1;
      r = s_axi_bresp;
      if (s_axi_awvalid && s_axi_awready) aw = 1;
      if (aw) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) w = 1;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (!b) tout("write");
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    bit got = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 50 && !got; i++) begin
      @(posedge aclk);
      if (s_axi_rvalid === 1'b1) got = 1;
      d = s_axi_rdata;
      r = s_axi_rresp;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (!got) tout("read");
  endtask
  // disable and set up, load values, then enable last
  task automatic cfg(input timer_pkg::mode_t md, input logic p,
    input logic [2:0] n, input logic [15:0] s, rl, m);
    timer_pkg::ctrl_t c;
    logic [1:0] r;
    c = '{out_af: 1'b1, output_polarity_select: p, presc: n, mode: md,
          en: 1'b0};
    wr(`TMR_CTRL_OFS, {24'h0, c}, r);
    wr(`TMR_COUNT_OFS, {16'h0, s}, r);
    wr(`TMR_RELOAD_OFS, {16'h0, rl}, r);
    wr(`TMR_MATCH_OFS, {16'h0, m}, r);
    irq_q.delete();
    c.en = 1'b1;
    wr(`TMR_CTRL_OFS, {24'h0, c}, r);
    t0 = cyc;
  endtask
  task automatic wait_irq(input int n);
    for (int i = 0; i < 2000 && irq_q.size() < n; i++) @(posedge aclk);
    if (irq_q.size() < n) tout("interrupt wait");
  endtask
  // main sequence
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          n, rl, s, m, hi, pl, base, i;
    void'($urandom(32'h8718CAD5));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`TMR_CTRL_OFS, d, r);
    chk(d, 32'h0, "control reset value");
    rd(8'h20, d, r);
    chk(r, `AXI_RESP_SLVERR, "unmapped read response");
    wr(8'h24, 32'h1, r);
    chk(r, `AXI_RESP_SLVERR, "unmapped write response");
    wr(`TMR_STATUS_OFS, 32'hFF, r);
    rd(`TMR_STATUS_OFS, d, r);
    chk(d, 32'h0, "status stays read-only");
    // continuous, the second run crosses the wrap point
    for (int k = 0; k < 2; k++) begin
      n = $urandom_range(2);
      rl = $urandom_range(6, 3);
      s = k ? 16'hFFFE : $urandom_range(rl, 1);
      half <= 4'($urandom_range(5, 2));
      run <= 1'b1;
      cfg(timer_pkg::MODE_CONTINUOUS, k[0], 3'(n), 16'(s), 16'(rl), 16'h0);
      wait_irq(3);
      chk(irq_q[0] - t0, ((rl - s + 1) & 32'hFFFF) << n, "first pass");
      chk(irq_q[2] - irq_q[1], rl << n, "later pass");
    end
    // one-shot reloads once and stops
    rl = $urandom_range(6, 3);
    cfg(timer_pkg::MODE_ONESHOT, 1'b1, 3'd1, 16'h1, 16'(rl), 16'h0);
    // flip polarity while running for a lasting change at expiry
    wr(`TMR_CTRL_OFS, 32'h00000089, r);
    chk(timer_out, 1'b1, "one-shot level held");
    wait_irq(1);
    repeat (20) @(posedge aclk);
    chk(timer_out, 1'b0, "one-shot lasting level");
    chk(irq_q.size(), 1, "one-shot reload count");
    chk(irq_q[0] - t0, rl << 1, "one-shot period");
    rd(`TMR_COUNT_OFS, d, r);
    chk(d, 32'h1, "count after one-shot");
    rd(`TMR_STATUS_OFS, d, r);
    chk(d[1], 1'b0, "enable after one-shot");
    // pwm time at the starting level, both polarities
    for (int p = 0; p < 2; p++) begin
      n = $urandom_range(1);
      rl = $urandom_range(8, 4);
      m = $urandom_range(rl - 1, 1);
      s = $urandom_range(rl, 1);
      cfg(timer_pkg::MODE_PWM, p[0], 3'(n), 16'(s), 16'(rl), 16'(m));
      for (i = 0; i < 400; i++) begin
        @(posedge aclk);
        if (timer_irq === 1'b1) break;
      end
      if (i == 400) tout("pwm reload");
      hi = 0;
      for (int j = 0; j < (rl << n); j++) begin
        hi += (timer_out === p[0]);
        @(posedge aclk);
      end
      chk(hi, m << n, "pwm level time");
      chk(irq_q[0] - t0, (rl - s + 1) << n, "pwm first period");
    end
    // counter mode: selected pin edges only, prescaler ignored
    run <= 1'b0;
    pl = $urandom_range(1);
    half <= 4'($urandom_range(5, 2));
    cfg(timer_pkg::MODE_COUNTER, pl[0], 3'd7, 16'h1, 16'h3, 16'h0);
    base = pl ? rises : falls;
    run <= 1'b1;
    for (i = 0; i < 400 && (pl ? rises : falls) - base < 6; i++)
      @(posedge aclk);
    if (i == 400) tout("counter edges");
    run <= 1'b0;
    repeat (10) @(posedge aclk);
    chk(irq_q.size(), 2, "counter reloads");
    chk(timer_out_oe, 1'b1, "output enable on");
    wr(`TMR_CTRL_OFS, 32'h00000000, r);
    chk(timer_out_oe, 1'b0, "output enable off");
    stop_test();
  end
  // overall run limit
  initial begin
    repeat (90000) @(posedge aclk);
    tout("run limit");
  end
endmodule // reload_timer_bench

bind reload_timer reload_timer_props props (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
  .timer_out, .timer_out_oe, .timer_irq);
